// ==== core/irm_carrier_gen.v ====
// carrier generator: 8-bit high/low time counter with primary and secondary count sets
`timescale 1ns/100ps
`default_nettype none
`include "irm_defines.vh"

module irm_carrier_gen
(
	input  wire       clk,
	input  wire       rst,
	input  wire       tick,
	input  wire       run,
	input  wire       base,
	input  wire       fsk,
	input  wire       swap,
	input  wire [7:0] hi_pri,
	input  wire [7:0] lo_pri,
	input  wire [7:0] hi_sec,
	input  wire [7:0] lo_sec,
	output reg        carrier
);

	reg  [7:0] cnt;
	reg        use_sec;
	wire [7:0] cmp;

	// compare value follows phase and active set
	assign cmp = carrier ? (use_sec ? hi_sec : hi_pri) : (use_sec ? lo_sec : lo_pri);

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt     <= `IRM_RST_CNT8;
			carrier <= 1'b1;
			use_sec <= 1'b0;
		end
		else if (!run || base)
		begin
			// baseband keeps the carrier high; counting stays idle
			cnt     <= `IRM_CNT_START;
			carrier <= 1'b1;
			use_sec <= 1'b0;
		end
		else
		begin
			if (fsk && swap)
				use_sec <= ~use_sec;
			if (tick)
			begin
				if (cnt == cmp)
				begin
					cnt     <= `IRM_CNT_START;
					carrier <= ~carrier;
				end
				else
					cnt <= cnt + 8'h01;
			end
		end
	end

endmodule // irm_carrier_gen
`default_nettype wire

// ==== core/irm_defines.vh ====
// constants for the infrared carrier modulator output block
`ifndef IRM_DEFINES_VH
`define IRM_DEFINES_VH

// ****************************************
// register word indices, decoded from address bits 4:2
// ****************************************
`define IRM_OFF_MSC      4'h0
`define IRM_OFF_OC       4'h1
`define IRM_OFF_CPRI     4'h2
`define IRM_OFF_CSEC     4'h3
`define IRM_OFF_MARK     4'h4
`define IRM_OFF_SPACE    4'h5
`define IRM_OFF_STAT     4'h6
`define IRM_OFF_NONE     4'hF

// ****************************************
// field positions
// ****************************************
`define IRM_MSC_MODULATOR_ENABLE    0
`define IRM_MSC_BASE     1
`define IRM_MSC_FSK      2
`define IRM_MSC_EXSP     3
`define IRM_MSC_DIV_LO   4
`define IRM_MSC_DIV_HI   5
`define IRM_MSC_EOCIE    6
`define IRM_MSC_EOCF     7
`define IRM_OC_LATCH     0
`define IRM_OC_PINEN     1

// ****************************************
// reset values and codes
// ****************************************
`define IRM_RST_MSC      8'h00
`define IRM_RST_OC       2'h0
`define IRM_RST_CNT8     8'h01
`define IRM_RST_CNT16    16'h0001
`define IRM_CNT_START    8'h01
`define IRM_RESP_OKAY    2'h0
`define IRM_RESP_SLVERR  2'h2
`define IRM_ONE17        17'h00001

`endif

// ==== core/irm_modulator.v ====
// modulator: 17-bit down counter timing mark, then space, with underflow detection
`timescale 1ns/100ps
`default_nettype none
`include "irm_defines.vh"

module irm_modulator
(
	input  wire        clk,
	input  wire        rst,
	input  wire        tick,
	input  wire        run,
	input  wire [15:0] mark,
	input  wire [15:0] space,
	output wire        gate,
	output reg         eoc
);

	reg [16:0] cnt;

	// sign bit clear means the mark is still running
	assign gate = run & ~cnt[16];

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt <= {1'b0, `IRM_RST_CNT16};
			eoc <= 1'b0;
		end
		else
		begin
			eoc <= 1'b0;
			if (!run)
				cnt <= {1'b0, mark};
			else if (tick)
			begin
				if (cnt[16] && (~cnt[15:0] == space))
				begin
					cnt <= {1'b0, mark};
					eoc <= 1'b1;
				end
				else
					cnt <= cnt - `IRM_ONE17;
			end
		end
	end

endmodule // irm_modulator
`default_nettype wire

// ==== core/irm_top.v ====
// infrared carrier modulator: AXI4-Lite registers, prescaler and output pin control
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "irm_defines.vh"

module irm_top
(
	input  wire        clk,
	input  wire        rst,
	input  wire [31:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [31:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg         infrared_out_pin_o,
	output reg         infrared_out_pin_oe,
	output reg         eoc_irq
);

	// ****************************************
	// address decode
	// ****************************************
	function [3:0] reg_sel;
		input [31:0] addr;
		begin
			if (addr[1:0] != 2'h0 || addr[31:5] != 27'h0)
				reg_sel = `IRM_OFF_NONE;
			else if (addr[4:2] == 3'h0)
				reg_sel = `IRM_OFF_MSC;
			else if (addr[4:2] == 3'h1)
				reg_sel = `IRM_OFF_OC;
			else if (addr[4:2] == 3'h2)
				reg_sel = `IRM_OFF_CPRI;
			else if (addr[4:2] == 3'h3)
				reg_sel = `IRM_OFF_CSEC;
			else if (addr[4:2] == 3'h4)
				reg_sel = `IRM_OFF_MARK;
			else if (addr[4:2] == 3'h5)
				reg_sel = `IRM_OFF_SPACE;
			else if (addr[4:2] == 3'h6)
				reg_sel = `IRM_OFF_STAT;
			else
				reg_sel = `IRM_OFF_NONE;
		end
	endfunction

	// ****************************************
	// registers
	// ****************************************
	reg  [7:0]  msc;
	reg  [1:0]  oc;
	reg  [15:0] cpri;
	reg  [15:0] csec;
	reg  [15:0] mark;
	reg  [15:0] space;
	reg  [2:0]  pre_cnt;
	reg         tick;

	wire        mod_en   = msc[`IRM_MSC_MODULATOR_ENABLE];
	wire        base     = msc[`IRM_MSC_BASE];
	wire        fsk      = msc[`IRM_MSC_FSK];
	wire        ext_sp   = msc[`IRM_MSC_EXSP];
	wire [1:0]  div_sel  = msc[`IRM_MSC_DIV_HI:`IRM_MSC_DIV_LO];
	wire        carrier;
	wire        gate;
	wire        eoc;

	wire        wr_go    = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
	wire        rd_go    = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
	wire [3:0]  wsel     = reg_sel(s_axi_awaddr);
	wire [3:0]  rsel     = reg_sel(s_axi_araddr);
	wire        clr_eocf = wr_go && wsel == `IRM_OFF_MSC && s_axi_wstrb[0] && s_axi_wdata[`IRM_MSC_EOCF];

	// ****************************************
	// write channel
	// ****************************************
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `IRM_RESP_OKAY;
			msc           <= `IRM_RST_MSC;
			oc            <= `IRM_RST_OC;
			cpri          <= {`IRM_RST_CNT8, `IRM_RST_CNT8};
			csec          <= {`IRM_RST_CNT8, `IRM_RST_CNT8};
			mark          <= `IRM_RST_CNT16;
			space         <= `IRM_RST_CNT16;
		end
		else
		begin
			s_axi_awready <= wr_go;
			s_axi_wready  <= wr_go;
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wsel == `IRM_OFF_NONE) ? `IRM_RESP_SLVERR : `IRM_RESP_OKAY;
				if (wsel == `IRM_OFF_MSC && s_axi_wstrb[0])
					msc[`IRM_MSC_EOCIE:0] <= s_axi_wdata[`IRM_MSC_EOCIE:0];
				else if (wsel == `IRM_OFF_OC && s_axi_wstrb[0])
					oc <= s_axi_wdata[1:0];
				else if (wsel == `IRM_OFF_CPRI)
				begin
					if (s_axi_wstrb[0])
						cpri[7:0] <= s_axi_wdata[7:0];
					if (s_axi_wstrb[1])
						cpri[15:8] <= s_axi_wdata[15:8];
				end
				else if (wsel == `IRM_OFF_CSEC)
				begin
					if (s_axi_wstrb[0])
						csec[7:0] <= s_axi_wdata[7:0];
					if (s_axi_wstrb[1])
						csec[15:8] <= s_axi_wdata[15:8];
				end
				else if (wsel == `IRM_OFF_MARK)
				begin
					if (s_axi_wstrb[0])
						mark[7:0] <= s_axi_wdata[7:0];
					if (s_axi_wstrb[1])
						mark[15:8] <= s_axi_wdata[15:8];
				end
				else if (wsel == `IRM_OFF_SPACE)
				begin
					if (s_axi_wstrb[0])
						space[7:0] <= s_axi_wdata[7:0];
					if (s_axi_wstrb[1])
						space[15:8] <= s_axi_wdata[15:8];
				end
			end
			// end-of-cycle flag: a new event beats a same-cycle clear
			if (eoc)
				msc[`IRM_MSC_EOCF] <= 1'b1;
			else if (clr_eocf)
				msc[`IRM_MSC_EOCF] <= 1'b0;
		end
	end

	// ****************************************
	// read channel
	// ****************************************
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `IRM_RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= rd_go;
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (rd_go)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `IRM_RESP_OKAY;
				if (rsel == `IRM_OFF_MSC)
					s_axi_rdata <= {24'h000000, msc};
				else if (rsel == `IRM_OFF_OC)
					s_axi_rdata <= {30'h00000000, oc};
				else if (rsel == `IRM_OFF_CPRI)
					s_axi_rdata <= {16'h0000, cpri};
				else if (rsel == `IRM_OFF_CSEC)
					s_axi_rdata <= {16'h0000, csec};
				else if (rsel == `IRM_OFF_MARK)
					s_axi_rdata <= {16'h0000, mark};
				else if (rsel == `IRM_OFF_SPACE)
					s_axi_rdata <= {16'h0000, space};
				else if (rsel == `IRM_OFF_STAT)
					s_axi_rdata <= {29'h00000000, infrared_out_pin_o, carrier, gate};
				else
				begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `IRM_RESP_SLVERR;
				end
			end
		end
	end

	// ****************************************
	// prescaler
	// ****************************************
	// one tick per 1, 2, 4 or 8 clocks, shared by both counters
	wire [2:0] div_mask = (div_sel == 2'h0) ? 3'h0 :
	                      (div_sel == 2'h1) ? 3'h1 :
	                      (div_sel == 2'h2) ? 3'h3 : 3'h7;

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pre_cnt <= 3'h0;
			tick    <= 1'b0;
		end
		else if (!mod_en)
		begin
			pre_cnt <= 3'h0;
			tick    <= 1'b0;
		end
		else
		begin
			pre_cnt <= pre_cnt + 3'h1;
			tick    <= ((pre_cnt & div_mask) == div_mask);
		end
	end

	// ****************************************
	// carrier and modulator
	// ****************************************
	irm_carrier_gen u_carrier
	(
		.clk     (clk),
		.rst     (rst),
		.tick    (tick),
		.run     (mod_en),
		.base    (base),
		.fsk     (fsk),
		.swap    (eoc),
		.hi_pri  (cpri[7:0]),
		.lo_pri  (cpri[15:8]),
		.hi_sec  (csec[7:0]),
		.lo_sec  (csec[15:8]),
		.carrier (carrier)
	);

	irm_modulator u_mod
	(
		.clk   (clk),
		.rst   (rst),
		.tick  (tick),
		.run   (mod_en),
		.mark  (mark),
		.space (space),
		.gate  (gate),
		.eoc   (eoc)
	);

	// ****************************************
	// transmitter output
	// ****************************************
	// extended space closes the gate whatever the carrier mode
	wire mod_out = gate & carrier & ~ext_sp;

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			infrared_out_pin_o  <= 1'b0;
			infrared_out_pin_oe <= 1'b0;
			eoc_irq             <= 1'b0;
		end
		else
		begin
			infrared_out_pin_oe <= oc[`IRM_OC_PINEN];
			if (!oc[`IRM_OC_PINEN])
				infrared_out_pin_o <= 1'b0;
			else if (mod_en)
				infrared_out_pin_o <= mod_out;
			else
				infrared_out_pin_o <= oc[`IRM_OC_LATCH];
			eoc_irq <= msc[`IRM_MSC_EOCF] & msc[`IRM_MSC_EOCIE];
		end
	end

endmodule // irm_top
`default_nettype wire

// ==== verif/irm_emitter.sv ====
// infrared emitter on the output pin
`timescale 1ns/100ps
`default_nettype none
module irm_emitter
(
	input  wire logic pin_o,
	input  wire logic pin_oe,
	output wire logic lit
);
	// released pin rests on its pull-down, emitter dark
	assign lit = pin_oe ? pin_o : 1'h0;
endmodule // irm_emitter
`default_nettype wire

// ==== verif/irm_monitor.sv ====
// bus and pin checker for the carrier modulator output block
`timescale 1ns/100ps
`default_nettype none
module irm_monitor
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        infrared_out_pin_o,
	input wire logic        infrared_out_pin_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_wr_take;
		s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
	endsequence
	sequence s_wr_ans;
		s_axi_awready && s_axi_wready && s_axi_bvalid;
	endsequence
	property p_wr_ans; s_wr_take |=> s_wr_ans; endproperty
	a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
	property p_aw_pulse; s_axi_awready |=> !s_axi_awready && !s_axi_wready; endproperty
	a_aw_pulse: assert property (p_aw_pulse) else $error("write ready too long");
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_rd_ans; s_axi_arvalid && !s_axi_rvalid && !s_axi_arready |=> s_axi_arready && s_axi_rvalid; endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
	property p_ar_pulse; s_axi_arready |=> !s_axi_arready; endproperty
	a_ar_pulse: assert property (p_ar_pulse) else $error("read ready too long");
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data not held");
	property p_pin_off; !infrared_out_pin_oe |-> !infrared_out_pin_o; endproperty
	a_pin_off: assert property (p_pin_off) else $error("released pin not low");
	// pin enable only moves on the edge after a write is answered
	property p_pin_cause; $changed(infrared_out_pin_oe) |-> $past(s_axi_bvalid); endproperty
	a_pin_cause: assert property (p_pin_cause) else $error("pin enable moved alone");
endmodule // irm_monitor
bind irm_top irm_monitor irm_monitor_i (.clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.infrared_out_pin_o, .infrared_out_pin_oe);
`default_nettype wire

// ==== verif/test_ir_carrier_modulator_output.sv ====
// self-checking bench for the infrared carrier modulator output block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin \
	$display("[ERR] %s exp %0h got %0h", nm, ex, got); err_count++; end end
module test_ir_carrier_modulator_output;
	typedef struct packed {logic [31:0] msc; logic [31:0] oc; logic oe; logic o;} irm_row_t;
	logic        clk     = 1'h0;
	logic        rst     = 1'h1;
	logic [31:0] awaddr  = 32'h0;
	logic [31:0] wdata   = 32'h0;
	logic [31:0] araddr  = 32'h0;
	logic        awvalid = 1'h0;
	logic        wvalid  = 1'h0;
	logic        bready  = 1'h0;
	logic        arvalid = 1'h0;
	logic        rready  = 1'h0;
	wire         awready, wready, bvalid, arready, rvalid, pin_o, pin_oe, irq, lit;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	logic [31:0] d;
	logic [1:0]  r;
	int          err_count = 0;
	int          total_checks = 0;
	int          cycles = 0;
	int          hi, lo, k, n, m;
	irm_row_t    rows [4] = '{'{32'h0, 32'h0, 1'h0, 1'h0}, '{32'h0, 32'h2, 1'h1, 1'h0},
		'{32'h0, 32'h3, 1'h1, 1'h1}, '{32'h1, 32'h1, 1'h0, 1'h0}};
	irm_top irm_top_i
	(
		.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .infrared_out_pin_o(pin_o),
		.infrared_out_pin_oe(pin_oe), .eoc_irq(irq)
	);
	irm_emitter irm_emitter_i (.pin_o(pin_o), .pin_oe(pin_oe), .lit(lit));
	initial forever #50 clk = ~clk;
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_count++;
			final_report;
		end
	end
	task final_report;
		if (err_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task step;
		@(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] v);
		@(posedge clk);
		awaddr  <= a;
		wdata   <= v;
		awvalid <= 1'h1;
		wvalid  <= 1'h1;
		bready  <= 1'h1;
		do
		begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'h0;
			if (wready)
				wvalid <= 1'h0;
		end
		while (!bvalid);
		r = bresp;
		bready <= 1'h0;
	endtask
	task automatic rd(input logic [31:0] a);
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'h1;
		rready  <= 1'h1;
		do
		begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'h0;
		end
		while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'h0;
	endtask
	// one full high run and low run of the emitter, skipping a partial first run
	task measure;
		hi = 0;
		lo = 0;
		@(negedge lit);
		@(posedge lit);
		while (lit)
		begin
			step;
			hi++;
		end
		while (!lit)
		begin
			step;
			lo++;
		end
	endtask
	initial
	begin
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		rd(32'h0);
		`CHK("msc_reset", 32'h0, d)
		rd(32'h8);
		`CHK("carrier_reset", 32'h101, d)
		rd(32'h40);
		`CHK("bad_read", 34'h200000000, {r, d})
		wr(32'h40, 32'hFF);
		`CHK("bad_write", 2'h2, r)
		for (k = 0; k < 4; k++)
		begin
			wr(32'h0, rows[k].msc);
			wr(32'h4, rows[k].oc);
			step;
			`CHK("pin", {rows[k].oe, rows[k].o}, {pin_oe, pin_o})
		end
		// time mode: one clock high, three low, long mark
		wr(32'h0, 32'h0);
		wr(32'h8, 32'h301);
		wr(32'h10, 32'hFF);
		wr(32'h14, 32'h1);
		wr(32'h4, 32'h2);
		wr(32'h0, 32'h1);
		measure;
		`CHK("carrier", 64'h100000003, {hi, lo})
		for (k = 0; k < 4; k++)
		begin
			wr(32'h0, 32'h0);
			wr(32'h10, 32'h2);
			wr(32'h14, 32'h4);
			wr(32'h0, 32'h3 | (k << 4));
			measure;
			`CHK("mark_space", {int'(3 << k), int'(5 << k)}, {hi, lo})
		end
		wr(32'h0, 32'h0);
		wr(32'h0, 32'hB);
		n = 0;
		repeat (60)
		begin
			step;
			n += lit;
		end
		`CHK("ext_space", 0, n)
		wr(32'h0, 32'h0);
		wr(32'h4, 32'h0);
		wr(32'h0, 32'h43);
		n = 0;
		m = 0;
		repeat (30)
		begin
			step;
			n += irq;
			m += pin_oe;
		end
		`CHK("timer_irq", 2'h1, {n == 0, n != 0})
		`CHK("timer_pin", 0, m)
		// stop the timer first so no late event can beat the clear
		wr(32'h0, 32'h40);
		step;
		`CHK("irq_hold", 1'h1, irq)
		wr(32'h0, 32'hC0);
		step;
		`CHK("irq_clear", 1'h0, irq)
		// fsk: primary set until the first cycle end, secondary until the second
		wr(32'h0, 32'h0);
		wr(32'hC, 32'h402);
		wr(32'h10, 32'hFF);
		wr(32'h14, 32'h1);
		wr(32'h4, 32'h2);
		wr(32'h0, 32'h5);
		measure;
		`CHK("fsk_pri", 64'h100000003, {hi, lo})
		repeat (270) step;
		measure;
		`CHK("fsk_sec", 64'h200000004, {hi, lo})
		final_report;
	end
endmodule // test_ir_carrier_modulator_output
`default_nettype wire
